// ==== shared/pin_mux_pkg.sv ====
// Constants, register map and mode codes for the upper three bits of the general-purpose port mux.
// Assumes a 32-bit Avalon-MM register bus with word addressing by byte address.
package pin_mux_pkg;
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 4;
    localparam int unsigned DATA_WIDTH = 32;
    localparam logic [ADDR_WIDTH-1:0] PIN_LEVEL_ADDR = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] OUTPUT_LATCH_ADDR = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] DIRECTION_CTRL_ADDR = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] FUNC_CTRL_ADDR = 4'hC;
    localparam logic [PORT_WIDTH-1:0] OUTPUT_LATCH_RESET = 8'h00;
    localparam logic [PORT_WIDTH-1:0] DIRECTION_CTRL_RESET = 8'hFF;
    localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int unsigned BIT_SDI = 5;
    localparam int unsigned BIT_SCK = 6;
    localparam int unsigned BIT_SS = 7;
    localparam int unsigned FC_MEM_EN = 0;
    localparam int unsigned FC_PSP_EN = 1;
    localparam int unsigned FC_SER_EN = 2;
    localparam int unsigned FC_I2C_MODE = 3;
    localparam int unsigned FC_I2C_SMB = 4;
    localparam int unsigned FC_WIDTH = 5;
    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;
endpackage

// ==== shared/pin_ctrl_if.sv ====
// Carrier of per-pin controls between the mux top and its pin-level selector.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface pin_ctrl_if;
    logic mem_en;
    logic mem_drive;
    logic mem_out;
    logic psp_en;
    logic psp_read;
    logic ser_en;
    logic ser_drive;
    logic ser_out;
    logic latch_bit;
    logic dir_bit;
    logic pin_out;
    logic pin_oe;
    modport top(output mem_en, mem_drive, mem_out, psp_en, psp_read, ser_en, ser_drive, ser_out,
                output latch_bit, dir_bit, input pin_out, pin_oe);
    modport sel(input mem_en, mem_drive, mem_out, psp_en, psp_read, ser_en, ser_drive, ser_out,
                input latch_bit, dir_bit, output pin_out, pin_oe);
endinterface

// ==== hw/pin_select.sv ====
// Output selector for one port pin: picks the driving function and the enable.
// Assumes the top registers the result before it reaches the pin.
`timescale 1ns/10ps
module pin_select
(
    pin_ctrl_if.sel ctrl
);
    wire mem_sel = ctrl.mem_en;
    wire ser_sel = !mem_sel && ctrl.ser_en && ctrl.ser_drive;
    wire psp_sel = !mem_sel && !ser_sel && ctrl.psp_en;
    // Memory and slave port set direction themselves; the direction bit is ignored for them.
    assign ctrl.pin_out = mem_sel ? ctrl.mem_out : ser_sel ? ctrl.ser_out : ctrl.latch_bit; // RL15 RL5
    assign ctrl.pin_oe = mem_sel ? ctrl.mem_drive : ser_sel ? 1'b1 : psp_sel ? ctrl.psp_read : !ctrl.dir_bit; // RL13 RL14
endmodule

// ==== hw/port_d_upper_pin_mux.sv ====
// Pin multiplexer for port bits 5 to 7 with memory bus, slave port and serial module functions.
// Assumes an Avalon-MM master on sys_clk and an external pad model resolving pin enables.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Contract
// RL1: Memory interface drives address/data on pins 5 and 6 over all other functions.
// RL2: Memory interface drives pin 7 ahead of slave port and latch.
// RL3: Memory read phases take pins 5 to 7 as data inputs to the interface.
// RL4: Memory function exists only when the large-package parameter is set.
// RL5: Slave port host read drives latch bits onto the pins.
// RL6: Slave port host write: host drives pins, device captures them.
// RL7: Pin 5 input feeds SPI data in when serial module is in SPI mode.
// RL8: I2C mode: pin 5 is open data line, drive beats slave port and port.
// RL9: I2C data input threshold chosen by a module setting; the block ignores FC_I2C_SMB and leaves the threshold to the pad.
// RL10: SPI mode: pin 6 drives clock when direction 0, receives when 1.
// RL11: I2C mode: pin 6 carries clock, driven with priority, selectable input type; the block leaves the input type to the pad.
// RL12: Pin 7 input delivers external slave select to serial module.
// RL13: Memory and slave port functions set direction, ignoring the direction bit.
// RL14: No function: direction 0 drives latch, 1 floats and samples pin level.
// RL15: Priority: memory, serial, slave port read, port latch.
module port_d_upper_pin_mux
#(
    parameter bit HAS_MEM_IF = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Avalon-MM register slave
    input wire logic [pin_mux_pkg::ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pin_mux_pkg::DATA_WIDTH-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pin_mux_pkg::DATA_WIDTH-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Memory interface side
    input wire logic mem_drive,
    input wire logic [2:0] mem_addr_data_out,
    output logic [2:0] mem_addr_data_in,
    // Parallel slave port side
    input wire logic psp_host_read,
    output logic [2:0] slave_port_write_data,
    // Second serial module side
    input wire logic spi_data_out_unused,
    input wire logic i2c_data_line_low,
    input wire logic i2c_clock_line_low,
    input wire logic spi_clock_line_out,
    output logic serial_data_in,
    output logic serial_clock_in,
    output logic serial_slave_select,
    // Pins 5 to 7
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe
);
    import pin_mux_pkg::*;

    logic [PORT_WIDTH-1:0] output_latch;
    logic [PORT_WIDTH-1:0] direction_ctrl;
    logic [PORT_WIDTH-1:0] pin_level;
    logic [FC_WIDTH-1:0] func_ctrl;
    logic [2:0] pin_sync1;
    logic [2:0] pin_sync2;
    bus_state_t bus_state;
    bus_state_t next_bus_state;

    // Byte lane 0 merge for 8-bit registers.
    function automatic logic [PORT_WIDTH-1:0] merge_byte(input logic [PORT_WIDTH-1:0] old,
                                                          input logic [DATA_WIDTH-1:0] wd,
                                                          input logic be0);
        merge_byte = be0 ? wd[PORT_WIDTH-1:0] : old;
    endfunction

    // Zero-extends an 8-bit register to the bus width.
    function automatic logic [DATA_WIDTH-1:0] widen_byte(input logic [PORT_WIDTH-1:0] value);
        widen_byte = {{(DATA_WIDTH-PORT_WIDTH){1'b0}}, value};
    endfunction

    // Passes a synchronised pin to a serial input, or holds the input idle high.
    function automatic logic route_bit(input logic route, input logic sample);
        route_bit = route ? sample : 1'b1;
    endfunction

    wire mem_active = HAS_MEM_IF && func_ctrl[FC_MEM_EN]; // RL4
    wire psp_active = func_ctrl[FC_PSP_EN];
    wire ser_active = func_ctrl[FC_SER_EN];
    wire i2c_mode = func_ctrl[FC_I2C_MODE];
    wire spi_mode = ser_active && !i2c_mode;
    wire i2c_active = ser_active && i2c_mode;
    wire bus_req = avs_read || avs_write;
    wire take = (bus_state == BUS_ACK) && bus_req;
    wire hit_level = avs_address == PIN_LEVEL_ADDR;
    wire hit_latch = avs_address == OUTPUT_LATCH_ADDR;
    wire hit_dir = avs_address == DIRECTION_CTRL_ADDR;
    wire hit_func = avs_address == FUNC_CTRL_ADDR;
    logic [DATA_WIDTH-1:0] read_mux;
    wire wr_latch = take && avs_write && (hit_latch || hit_level);
    wire wr_take = take && avs_write;
    wire wr_dir = wr_take && hit_dir;
    wire wr_func = wr_take && hit_func && avs_byteenable[0];

    // Register read selection; unmapped offsets read as zero.
    always_comb
    begin
        if (hit_level)
        begin
            read_mux = widen_byte(pin_level);
        end
        else if (hit_latch)
        begin
            read_mux = widen_byte(output_latch);
        end
        else if (hit_dir)
        begin
            read_mux = widen_byte(direction_ctrl);
        end
        else if (hit_func)
        begin
            read_mux = {{(DATA_WIDTH-FC_WIDTH){1'b0}}, func_ctrl};
        end
        else
        begin
            read_mux = UNMAPPED_READ;
        end
    end

    // One wait cycle per access: idle takes the request, ack completes it.
    always_comb
    begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE:
            begin
                if (bus_req)
                begin
                    next_bus_state = BUS_ACK;
                end
            end
            BUS_ACK:
            begin
                next_bus_state = BUS_IDLE;
            end
            default:
            begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            bus_state <= BUS_IDLE;
        end
        else
        begin
            bus_state <= next_bus_state;
        end
    end

    // Waitrequest drops for the ack cycle; read data follow the decoder every cycle.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= UNMAPPED_READ;
        end
        else
        begin
            avs_waitrequest <= !(next_bus_state == BUS_ACK);
            avs_readdata <= read_mux;
        end
    end

    // Writes to the pin level register land in the output latch.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            output_latch <= OUTPUT_LATCH_RESET;
        end
        else if (wr_latch)
        begin
            output_latch <= merge_byte(output_latch, avs_writedata, avs_byteenable[0]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            direction_ctrl <= DIRECTION_CTRL_RESET;
        end
        else if (wr_dir)
        begin
            direction_ctrl <= merge_byte(direction_ctrl, avs_writedata, avs_byteenable[0]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            func_ctrl <= '0;
        end
        else if (wr_func)
        begin
            func_ctrl <= avs_writedata[FC_WIDTH-1:0];
        end
    end

    // Pin inputs pass two flip-flops before any logic reads them.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_sync1 <= 3'h0;
            pin_sync2 <= 3'h0;
        end
        else
        begin
            pin_sync1 <= gpio_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // One sample stands for TTL, Schmitt and I2C thresholds alike; the pad sets the threshold.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_level <= 8'h00;
        end
        else
        begin
            pin_level <= {pin_sync2, 5'h00}; // RL14
        end
    end

    wire sdi_route = (spi_mode && direction_ctrl[BIT_SDI]) || i2c_active; // RL7 RL9
    wire sck_route = ser_active && direction_ctrl[BIT_SCK]; // RL10 RL11
    wire ss_route = spi_mode && direction_ctrl[BIT_SS]; // RL12
    wire psp_capture = psp_active && !psp_host_read; // RL6

    // Memory read data, zero while the interface is off.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            mem_addr_data_in <= 3'h0;
        end
        else
        begin
            mem_addr_data_in <= mem_active ? pin_sync2 : 3'h0; // RL3
        end
    end

    // Slave port write data, zero unless the host is writing.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            slave_port_write_data <= 3'h0;
        end
        else
        begin
            slave_port_write_data <= psp_capture ? pin_sync2 : 3'h0; // RL6
        end
    end

    // Serial inputs idle high unless their route is on; the routes do not check the memory function.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            serial_data_in <= 1'b1;
            serial_clock_in <= 1'b1;
            serial_slave_select <= 1'b1;
        end
        else
        begin
            serial_data_in <= route_bit(sdi_route, pin_sync2[0]); // RL7 RL9
            serial_clock_in <= route_bit(sck_route, pin_sync2[1]); // RL10 RL11
            serial_slave_select <= route_bit(ss_route, pin_sync2[2]); // RL12
        end
    end

    logic [2:0] sel_out;
    logic [2:0] sel_oe;
    // Pin 5 is driven by the serial module only as an I2C pull-low.
    wire sda_drive = i2c_active && i2c_data_line_low; // RL8
    // Pin 6 drives the SPI clock as master, or pulls the I2C clock low.
    wire scl_drive = i2c_active && i2c_clock_line_low; // RL11
    wire sck_drive = spi_mode && !direction_ctrl[BIT_SCK]; // RL10
    wire clk_drive = scl_drive || sck_drive;
    wire clk_value = sck_drive && spi_clock_line_out;
    wire [2:0] ser_drv = {1'b0, clk_drive, sda_drive}; // RL8 RL10 RL11
    wire [2:0] ser_val = {1'b0, clk_value, 1'b0};
    // In I2C mode without the memory function, pins 5 and 6 are open drain: released unless a pull-low is asked for.
    wire i2c_owns = i2c_active && !mem_active;
    wire [2:0] i2c_own = {1'b0, i2c_owns, i2c_owns}; // RL8 RL11
    wire [2:0] i2c_pull = {1'b0, i2c_clock_line_low, i2c_data_line_low};
    wire [2:0] pin_out_final = sel_out & ~i2c_own;
    wire [2:0] pin_oe_final = (sel_oe & ~i2c_own) | (i2c_pull & i2c_own);

    // One selector per pin; the interface carries its controls.
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_pin
            pin_ctrl_if ctrl();
            assign ctrl.mem_en = mem_active; // RL1 RL2
            assign ctrl.mem_drive = mem_drive;
            assign ctrl.mem_out = mem_addr_data_out[g];
            assign ctrl.psp_en = psp_active;
            assign ctrl.psp_read = psp_host_read;
            assign ctrl.ser_en = ser_active;
            assign ctrl.ser_drive = ser_drv[g];
            assign ctrl.ser_out = ser_val[g];
            assign ctrl.latch_bit = output_latch[BIT_SDI + g];
            assign ctrl.dir_bit = direction_ctrl[BIT_SDI + g];
            assign sel_out[g] = ctrl.pin_out;
            assign sel_oe[g] = ctrl.pin_oe;
            pin_select u_sel (.ctrl(ctrl));
        end
    endgenerate

    // Pin drive and enable leave the block straight from flip-flops.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            gpio_out <= 3'h0;
        end
        else
        begin
            gpio_out <= pin_out_final; // RL15
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            gpio_oe <= 3'h0;
        end
        else
        begin
            gpio_oe <= pin_oe_final; // RL13 RL14
        end
    end
endmodule

// ==== verification/pin_mux_monitor.sv ====
// Port checker for the upper pin mux, bound into every instance.
// Assumes register writes land at the edge where waitrequest is sampled low.
`timescale 1ns/10ps
module pin_mux_monitor
import pin_mux_pkg::*;
#(parameter bit HAS_MEM_IF = 1'b1)
(
    // Clock, reset and register bus
    input wire logic sys_clk, input wire logic sys_rst, input wire logic [3:0] avs_address,
    input wire logic avs_write, input wire logic [31:0] avs_writedata, input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Function inputs
    input wire logic mem_drive, input wire logic [2:0] mem_addr_data_out, input wire logic psp_host_read,
    input wire logic i2c_data_line_low, input wire logic i2c_clock_line_low, input wire logic spi_clock_line_out,
    // Pins
    input wire logic [2:0] gpio_out, input wire logic [2:0] gpio_oe
);
    logic [4:0] fc;
    logic [2:0] dir, lat;
    wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [4:0] next_fc = wr_ok && avs_address == FUNC_CTRL_ADDR ? avs_writedata[4:0] : fc;
    wire [2:0] next_dir = wr_ok && avs_address == DIRECTION_CTRL_ADDR ? avs_writedata[7:5] : dir;
    wire [2:0] next_lat = wr_ok && avs_address[3] == 1'b0 && avs_address[1:0] == 2'h0 ? avs_writedata[7:5] : lat;
    wire mem = HAS_MEM_IF && fc[0];
    wire spi = !mem && fc[2] && !fc[3];
    wire i2c = !mem && fc[2] && fc[3];
    // Shadow registers track the design's copies so every pin check knows the set-up.
    always_ff @(posedge sys_clk)
        {fc, dir, lat} <= sys_rst ? {5'h00, 3'h7, 3'h0} : {next_fc, next_dir, next_lat};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_mem_drive; mem && mem_drive |=> gpio_oe == 3'h7 && gpio_out == $past(mem_addr_data_out); endproperty
    a_mem_drive: assert property (p_mem_drive) else $error("memory drive");
    property p_mem_read; mem && !mem_drive |=> gpio_oe == 3'h0; endproperty
    a_mem_read: assert property (p_mem_read) else $error("memory read");
    property p_psp_read; !mem && !fc[2] && fc[1] && psp_host_read |=> gpio_oe == 3'h7 && gpio_out == $past(lat); endproperty
    a_psp_read: assert property (p_psp_read) else $error("slave port read");
    property p_psp_write; !mem && !fc[2] && fc[1] && !psp_host_read |=> gpio_oe == 3'h0; endproperty
    a_psp_write: assert property (p_psp_write) else $error("slave port write");
    property p_i2c_data; i2c |=> gpio_oe[0] == $past(i2c_data_line_low) && !(gpio_oe[0] && gpio_out[0]); endproperty
    a_i2c_data: assert property (p_i2c_data) else $error("i2c data");
    property p_i2c_clock; i2c |=> gpio_oe[1] == $past(i2c_clock_line_low) && !(gpio_oe[1] && gpio_out[1]); endproperty
    a_i2c_clock: assert property (p_i2c_clock) else $error("i2c clock");
    property p_spi_clock; spi && !dir[1] |=> gpio_oe[1] && gpio_out[1] == $past(spi_clock_line_out); endproperty
    a_spi_clock: assert property (p_spi_clock) else $error("spi clock");
    property p_plain; fc[2:0] == 3'h0 |=> gpio_oe == ~$past(dir) && (gpio_out & gpio_oe) == ($past(lat) & gpio_oe); endproperty
    a_plain: assert property (p_plain) else $error("plain port");
    c_mem: cover property (mem && mem_drive);
    c_psp: cover property (fc[1] && psp_host_read);
    c_i2c: cover property (i2c);
endmodule
bind port_d_upper_pin_mux pin_mux_monitor #(.HAS_MEM_IF(HAS_MEM_IF)) i_pin_mux_monitor (.*);

// ==== verification/pin_pad_model.sv ====
// Far side of pins 5 to 7: host, memory, serial devices and pull-ups.
// Assumes external drivers act only where the mux releases the pin.
`timescale 1ns/10ps
module pin_pad_model
(
    // Mux side
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    // External drivers
    input wire logic [2:0] ext_data,
    input wire logic [2:0] ext_en,
    // Resolved level
    output logic [2:0] gpio_in
);
    // A pin nobody drives is pulled up instead of keeping its last value.
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ((ext_en & ext_data) | ~ext_en));
endmodule

// ==== verification/port_d_upper_pin_mux_tb_top.sv ====
// Bench for the upper pin mux: a table of pin set-ups, then reset and bus corner cases.
// Assumes the pad model closes the pins and the checker is bound into the mux.
`timescale 1ns/10ps
module port_d_upper_pin_mux_tb_top;
    import pin_mux_pkg::*;
    logic sys_clk = '0, sys_rst = '1, avs_read = '0, avs_write = '0, mem_drive = '0, psp_host_read = '0, md, hr;
    logic spi_data_out_unused = '0, i2c_data_line_low = '0, i2c_clock_line_low = '0, spi_clock_line_out = '0;
    logic avs_waitrequest, serial_data_in, serial_clock_in, serial_slave_select;
    logic [3:0] avs_address = '0, avs_byteenable = '0;
    logic [4:0] fc;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [2:0] mem_addr_data_out = '0, ext_data = '0, mem_addr_data_in, slave_port_write_data, gpio_in, gpio_out;
    logic [2:0] gpio_oe, dir, lat, eoe, eout, p;
    int n_fail = 0, num_checks = 0;
    // Row: func_ctrl, direction, latch, memory drive, host read, expected enables, expected drive.
    logic [18:0] rows [10] = '{19'h0_152D, 19'h1_FAFD, 19'h0_4200, 19'h0_BE7E, 19'h0_8600,
                               19'h1_2B12, 19'h1_3E00, 19'h3_3A08, 19'h7_3C10, 19'h3_78BF};
    port_d_upper_pin_mux i_port_d_upper_pin_mux (.*);
    pin_pad_model i_pin_pad_model (.gpio_out, .gpio_oe, .ext_data, .ext_en(3'h7), .gpio_in);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {w, !w, a, d, be};
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i])
        begin
            {fc, dir, lat, md, hr, eoe, eout} = rows[i];
            {mem_drive, psp_host_read, i2c_clock_line_low, i2c_data_line_low, spi_clock_line_out} <= {md, hr, lat};
            {mem_addr_data_out, ext_data} <= {~lat, ~lat};
            acc(1'b1, FUNC_CTRL_ADDR, 32'(fc), 4'hF);
            acc(1'b1, DIRECTION_CTRL_ADDR, 32'({dir, 5'h00}), 4'hF);
            acc(1'b1, OUTPUT_LATCH_ADDR, 32'({lat, 5'h00}), 4'hF);
            repeat (6) @(posedge sys_clk);
            p = (eout & eoe) | (~lat & ~eoe);
            chk(32'({gpio_oe, gpio_out & gpio_oe}), 32'({eoe, eout}));
            chk(32'({mem_addr_data_in, slave_port_write_data}),
                32'({fc[0] ? p : 3'h0, fc[1:0] == 2'h2 && !hr ? p : 3'h0}));
            if (fc[3:2] == 2'h1)
                chk(32'({serial_data_in, serial_slave_select}), 32'({p[0], p[2]}));
            chk(32'({serial_clock_in, serial_data_in}),
                32'({fc[2] && dir[1] ? p[1] : 1'b1, (fc[3:2] == 2'h1 && dir[0]) || fc[3:2] == 2'h3 ? p[0] : 1'b1}));
            acc(1'b0, PIN_LEVEL_ADDR, '0, 4'hF);
            chk(q, 32'({p, 5'h00}));
        end
        acc(1'b1, PIN_LEVEL_ADDR, 32'h0000_00A0, 4'hF);
        acc(1'b1, OUTPUT_LATCH_ADDR, 32'h0000_00FF, 4'h0);
        acc(1'b0, OUTPUT_LATCH_ADDR, '0, 4'hF);
        chk(q, 32'h0000_00A0);
        acc(1'b0, 4'h2, '0, 4'hF);
        chk(q, UNMAPPED_READ);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk(32'(gpio_oe), '0);
        acc(1'b0, DIRECTION_CTRL_ADDR, '0, 4'hF);
        chk(q, 32'(DIRECTION_CTRL_RESET));
        acc(1'b0, OUTPUT_LATCH_ADDR, '0, 4'hF);
        chk(q, 32'(OUTPUT_LATCH_RESET));
        report_and_stop();
    end
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule
